// >>> src/fac_top.sv
`timescale 1ns/1ps
// Behaviour
// - capture regardless of interrupt enabling
// - first failure after reset or clear
// - permission failure or overlap triggers capture
// - no update while status flag set
// - bit 24 direction, 1 write
// - bit 21 security, 1 non-secure
// - bit 20 privilege, 1 privileged
// - bits 27:24 virtual network number
// - low bits transaction id
// - separate capture registers per filter
// - one to four filter units
module fac_top
   import fac_pkg::*;
#(
   parameter int NUM_FILTERS = fac_pkg::FAC_MAX_FILTERS,
   parameter int ID_W        = fac_pkg::FAC_ID_W_DEF
) (
   input  wire logic                                   sys_clk,
   input  wire logic                                   sys_rst,
   input  wire logic [NUM_FILTERS-1:0]                 perm_fail,
   input  wire logic [NUM_FILTERS-1:0]                 region_overlap,
   input  wire logic [NUM_FILTERS-1:0]                 acc_write,
   input  wire logic [NUM_FILTERS-1:0]                 acc_nonsec,
   input  wire logic [NUM_FILTERS-1:0]                 acc_priv,
   input  wire logic [NUM_FILTERS*fac_pkg::FAC_VNET_W-1:0] read_virtual_network,
   input  wire logic [NUM_FILTERS*fac_pkg::FAC_VNET_W-1:0] write_virtual_network,
   input  wire logic [NUM_FILTERS*ID_W-1:0]            acc_id,
   input  wire logic [fac_pkg::FAC_ADDR_W-1:0]         reg_addr,
   input  wire logic [31:0]                            reg_wdata,
   input  wire logic                                   reg_wr,
   input  wire logic                                   reg_rd,
   output logic [31:0]                                 reg_rdata,
   output logic                                        irq
);
   import fac_pkg::*;

   logic [NUM_FILTERS-1:0] status;
   logic [NUM_FILTERS-1:0] mask_r;
   logic [NUM_FILTERS-1:0] clear_w;
   logic [NUM_FILTERS-1:0] fail_any;
   logic [31:0]            attr_w  [NUM_FILTERS];
   logic [31:0]            ident_w [NUM_FILTERS];
   logic [31:0]            rd_mux;
   logic [31:0]            rdata_r;
   logic                   wr_clear;
   logic                   wr_mask;

   assign wr_clear = reg_wr && (reg_addr == FAC_OFS_CLEAR);
   assign clear_w  = wr_clear ? reg_wdata[NUM_FILTERS-1:0] : '0;
   assign wr_mask  = reg_wr && (reg_addr == FAC_OFS_MASK);

   if (NUM_FILTERS < 1 || NUM_FILTERS > FAC_MAX_FILTERS) begin : g_bad_count
      $error("filter count out of range");
   end
   // id field must stay below the network number field
   if (ID_W < 1 || ID_W > FAC_VNET_LSB) begin : g_bad_id_w
      $error("transaction id width out of range");
   end

   for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_flt
      logic [FAC_VNET_W-1:0] vnet;
      assign vnet = acc_write[g] ? write_virtual_network[g*FAC_VNET_W +:
                                                          FAC_VNET_W]
                                 : read_virtual_network[g*FAC_VNET_W +:
                                                         FAC_VNET_W];
      assign fail_any[g] = perm_fail[g] | region_overlap[g];
      fac_unit #(.ID_W(ID_W)) u_unit (
         .sys_clk    (sys_clk),
         .sys_rst    (sys_rst),
         .fail_event (fail_any[g]),
         .clear      (clear_w[g]),
         .acc_write  (acc_write[g]),
         .acc_nonsec (acc_nonsec[g]),
         .acc_priv   (acc_priv[g]),
         .acc_vnet   (vnet),
         .acc_id     (acc_id[g*ID_W +: ID_W]),
         .status_r   (status[g]),
         .attr_r     (attr_w[g]),
         .ident_r    (ident_w[g])
      );
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= reg_wdata[NUM_FILTERS-1:0];
      end
   end

   // read decode; unmapped reads zero
   always_comb begin
      rd_mux = FAC_ZERO;
      if (reg_addr == FAC_OFS_STATUS)
         rd_mux[NUM_FILTERS-1:0] = status;
      else if (reg_addr == FAC_OFS_MASK)
         rd_mux[NUM_FILTERS-1:0] = mask_r;
      for (int i = 0; i < NUM_FILTERS; i++) begin
         if (reg_addr == FAC_OFS_BASE + 8'(i) * FAC_STRIDE + FAC_OFS_ATTR)
            rd_mux = attr_w[i];
         if (reg_addr == FAC_OFS_BASE + 8'(i) * FAC_STRIDE + FAC_OFS_IDENT)
            rd_mux = ident_w[i];
      end
   end

   // data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= FAC_ZERO;
      end else begin
         rdata_r <= reg_rd ? rd_mux : FAC_ZERO;
      end
   end
   assign reg_rdata = rdata_r;
   assign irq = |(status & mask_r);

   // checked on the irq output itself, the cycle after an enabled failure on filter 0
   a_irq_level : assert property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && mask_r[0] && !wr_mask |=> irq)
      else $error("enabled failure raised no interrupt");
   a_set_wins : assert property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && clear_w[0] |=> status[0])
      else $error("clear beat a new failure");
   a_vnet_pick : assert property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && !status[0] |=>
      ident_w[0][FAC_VNET_LSB +: FAC_VNET_W] == ($past(acc_write[0]) ?
      $past(write_virtual_network[FAC_VNET_W-1:0]) :
      $past(read_virtual_network[FAC_VNET_W-1:0])))
      else $error("network number from wrong channel");
   a_clear_rearm : assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_clear && reg_wdata[0] && !fail_any[0] |=> !status[0])
      else $error("clear did not rearm");
   a_overlap_set : assert property (@(posedge sys_clk) disable iff (sys_rst)
      region_overlap[0] |=> status[0])
      else $error("overlap not captured");
   a_mask_indep : assert property (@(posedge sys_clk) disable iff (sys_rst)
      perm_fail[0] && !status[0] && !mask_r[0] |=>
      attr_w[0][FAC_BIT_PRIV] == $past(acc_priv[0]))
      else $error("masked failure not captured");
   a_nonsec_cap : assert property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && !status[0] |=>
      attr_w[0][FAC_BIT_NONSEC] == $past(acc_nonsec[0]))
      else $error("security bit wrong");
   a_rd_timing : assert property (@(posedge sys_clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == FAC_ZERO)
      else $error("read data outside read slot");
   c_capture : cover property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && !status[0]);
   c_frozen : cover property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && status[0]);
   c_rearm : cover property (@(posedge sys_clk) disable iff (sys_rst)
      status[0] ##1 !status[0] ##[1:20] status[0]);
   c_set_clear : cover property (@(posedge sys_clk) disable iff (sys_rst)
      fail_any[0] && clear_w[0]);
endmodule

// >>> src/fac_pkg.sv
package fac_pkg;
   localparam int FAC_MAX_FILTERS   = 4;
   localparam int FAC_ID_W_DEF      = 8;
   localparam int FAC_VNET_W        = 4;
   localparam int FAC_ADDR_W        = 8;
   // register byte offsets, per filter stride 0x10
   localparam logic [7:0] FAC_OFS_STATUS = 8'h00;
   localparam logic [7:0] FAC_OFS_MASK   = 8'h04;
   localparam logic [7:0] FAC_OFS_CLEAR  = 8'h08;
   localparam logic [7:0] FAC_OFS_BASE   = 8'h10;
   localparam logic [7:0] FAC_STRIDE     = 8'h10;
   localparam logic [7:0] FAC_OFS_ATTR   = 8'h00;
   localparam logic [7:0] FAC_OFS_IDENT  = 8'h04;
   // field positions
   localparam int FAC_BIT_WRITE     = 24;
   localparam int FAC_BIT_NONSEC    = 21;
   localparam int FAC_BIT_PRIV      = 20;
   localparam int FAC_VNET_LSB      = 24;
   localparam int FAC_ID_LSB        = 0;
   localparam logic [31:0] FAC_ZERO = 32'h0000_0000;
endpackage

// >>> src/fac_unit.sv
`timescale 1ns/1ps
module fac_unit
   import fac_pkg::*;
#(
   parameter int ID_W = fac_pkg::FAC_ID_W_DEF
) (
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  fail_event,
   input  wire logic                  clear,
   input  wire logic                  acc_write,
   input  wire logic                  acc_nonsec,
   input  wire logic                  acc_priv,
   input  wire logic [FAC_VNET_W-1:0] acc_vnet,
   input  wire logic [ID_W-1:0]       acc_id,
   output logic                       status_r,
   output logic [31:0]                attr_r,
   output logic [31:0]                ident_r
);
   logic        load;
   logic [31:0] attr_nxt;
   logic [31:0] ident_nxt;

   assign load = fail_event && !status_r;

   always_comb begin
      attr_nxt = FAC_ZERO;
      ident_nxt = FAC_ZERO;
      attr_nxt[FAC_BIT_WRITE] = acc_write;
      attr_nxt[FAC_BIT_NONSEC] = acc_nonsec;
      attr_nxt[FAC_BIT_PRIV] = acc_priv;
      ident_nxt[FAC_VNET_LSB +: FAC_VNET_W] = acc_vnet;
      ident_nxt[FAC_ID_LSB +: ID_W] = acc_id;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         attr_r <= FAC_ZERO;
         ident_r <= FAC_ZERO;
      end else if (load) begin
         attr_r <= attr_nxt;
         ident_r <= ident_nxt;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_r <= 1'b0;
      end else if (fail_event) begin
         status_r <= 1'b1;
      end else if (clear) begin
         status_r <= 1'b0;
      end
   end

   a_frozen_hold : assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(status_r) && status_r |-> $stable(attr_r) && $stable(ident_r))
      else $error("capture changed while flagged");
   a_load_attr : assert property (@(posedge sys_clk) disable iff (sys_rst)
      fail_event && !status_r |=> attr_r[FAC_BIT_WRITE] == $past(acc_write)
      && ident_r[FAC_ID_LSB +: ID_W] == $past(acc_id))
      else $error("first failure not captured");
   a_status_set : assert property (@(posedge sys_clk) disable iff (sys_rst)
      fail_event |=> status_r)
      else $error("status not set on failure");
endmodule

// >>> sim/fac_master_model.sv
`timescale 1ns/1ps
module fac_master_model
   import fac_pkg::*;
#(
   parameter int NF   = 4,
   parameter int ID_W = 8
) (
   input  wire logic                sys_clk,
   output logic [NF-1:0]            perm_fail,
   output logic [NF-1:0]            region_overlap,
   output logic [NF-1:0]            acc_write,
   output logic [NF-1:0]            acc_nonsec,
   output logic [NF-1:0]            acc_priv,
   output logic [NF*FAC_VNET_W-1:0] read_virtual_network,
   output logic [NF*FAC_VNET_W-1:0] write_virtual_network,
   output logic [NF*ID_W-1:0]       acc_id
);
   initial begin
      {perm_fail, region_overlap, acc_write, acc_nonsec, acc_priv} = '0;
      {read_virtual_network, write_virtual_network, acc_id} = '0;
   end
   // one-cycle access; afterwards attributes flip so stale use shows
   task automatic access(input int g, input logic ovl, wr, ns, pv,
                         input logic [FAC_VNET_W-1:0] vn,
                         input logic [ID_W-1:0] id);
      @(posedge sys_clk);
      perm_fail[g] <= !ovl;
      region_overlap[g] <= ovl;
      {acc_write[g], acc_nonsec[g], acc_priv[g]} <= {wr, ns, pv};
      read_virtual_network[g*FAC_VNET_W +: FAC_VNET_W] <= vn;
      write_virtual_network[g*FAC_VNET_W +: FAC_VNET_W] <= ~vn;
      acc_id[g*ID_W +: ID_W] <= id;
      @(posedge sys_clk);
      {perm_fail[g], region_overlap[g]} <= 2'b00;
      {acc_write[g], acc_nonsec[g], acc_priv[g]} <= {!wr, !ns, !pv};
      read_virtual_network[g*FAC_VNET_W +: FAC_VNET_W] <= ~vn;
      write_virtual_network[g*FAC_VNET_W +: FAC_VNET_W] <= vn;
      acc_id[g*ID_W +: ID_W] <= ~id;
   endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
   import fac_pkg::*;
   logic sys_clk, sys_rst, reg_wr, reg_rd, irq;
   logic [3:0] pf, ro, aw, an, ap;
   logic [15:0] rvn, wvn;
   logic [31:0] aid, reg_wdata, reg_rdata, d;
   logic [7:0] reg_addr;
   int n_errors, samples_checked;
   fac_top #(.NUM_FILTERS(4), .ID_W(8)) dut (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .perm_fail(pf), .region_overlap(ro),
      .acc_write(aw), .acc_nonsec(an), .acc_priv(ap),
      .read_virtual_network(rvn), .write_virtual_network(wvn),
      .acc_id(aid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   fac_master_model #(.NF(4), .ID_W(8)) m (.sys_clk(sys_clk),
      .perm_fail(pf), .region_overlap(ro), .acc_write(aw),
      .acc_nonsec(an), .acc_priv(ap), .read_virtual_network(rvn),
      .write_virtual_network(wvn), .acc_id(aid));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      `CHK(d, e)
   endtask
   task automatic cap(input int g, input logic wr_, ns, pv,
                      input logic [3:0] vn, input logic [7:0] id);
      logic [7:0] a;
      logic [3:0] v;
      a = 8'(FAC_OFS_BASE + FAC_STRIDE * g);
      // write access takes the write-channel network number;
      // inverted at 4 bits so the cast cannot widen the inversion
      v = wr_ ? ~vn : vn;
      rd(a + FAC_OFS_ATTR, (32'(wr_) << FAC_BIT_WRITE)
         | (32'(ns) << FAC_BIT_NONSEC) | (32'(pv) << FAC_BIT_PRIV));
      rd(a + FAC_OFS_IDENT, (32'(v) << FAC_VNET_LSB) | 32'(id));
   endtask
   initial begin
      #100000 n_errors++;
      test_done();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      sys_rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(FAC_OFS_STATUS, FAC_ZERO);
      cap(3, 0, 0, 0, 4'h0, 8'h00);
      wr(FAC_OFS_MASK, 32'h0000_000F);
      for (int g = 0; g < 4; g++) begin
         m.access(g, 0, g[0], g[1], !g[0], 4'(g + 5),
                  8'(8'h30 + g));
      end
      // attributes and identity of one access
      for (int g = 0; g < 4; g++) begin
         cap(g, g[0], g[1], !g[0], 4'(g + 5), 8'(8'h30 + g));
      end
      rd(FAC_OFS_STATUS, 32'h0000_000F);
      `CHK(irq, 1'b1)
      m.access(0, 1, 1, 1, 0, 4'h9, 8'hEE);
      cap(0, 0, 0, 1, 4'h5, 8'h30);
      wr(FAC_OFS_CLEAR, 32'h0000_0001);
      rd(FAC_OFS_STATUS, 32'h0000_000E);
      m.access(0, 1, 0, 0, 1, 4'hC, 8'hA5);
      cap(0, 0, 0, 1, 4'hC, 8'hA5);
      m.access(0, 0, 1, 1, 0, 4'h2, 8'h11);
      cap(0, 0, 0, 1, 4'hC, 8'hA5);
      wr(FAC_OFS_MASK, FAC_ZERO);
      wr(FAC_OFS_CLEAR, 32'h0000_000F);
      m.access(1, 0, 1, 0, 1, 4'h6, 8'h5A);
      rd(FAC_OFS_STATUS, 32'h0000_0002);
      `CHK(irq, 1'b0)
      cap(1, 1, 0, 1, 4'h6, 8'h5A);
      // clear and a new failure in one cycle: the failure wins
      fork
         m.access(0, 0, 0, 1, 1, 4'h3, 8'h77);
         wr(FAC_OFS_CLEAR, 32'h0000_0001);
      join
      rd(FAC_OFS_STATUS, 32'h0000_0003);
      cap(0, 0, 1, 1, 4'h3, 8'h77);
      rd(FAC_OFS_CLEAR, FAC_ZERO);
      rd(8'hFC, FAC_ZERO);
      test_done();
   end
endmodule
